/* core/dio_regs_pkg.sv */
// Register map, field positions and timing constants of the isolated DIO block
package dio_regs_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [5:0] OFF_IN0 = 6'h00;
  localparam logic [5:0] OFF_IN1 = 6'h01;
  localparam logic [5:0] OFF_IN2 = 6'h02;
  localparam logic [5:0] OFF_RLY3 = 6'h03;
  localparam logic [5:0] OFF_RLY4 = 6'h04;
  localparam logic [5:0] OFF_RLY5 = 6'h05;
  localparam logic [5:0] OFF_IDENT = 6'h06;
  localparam logic [5:0] OFF_STROBE = 6'h07;
  localparam logic [5:0] OFF_PER_LO = 6'h08;
  localparam logic [5:0] OFF_PER_MID = 6'h09;
  localparam logic [5:0] OFF_PER_HI = 6'h0a;
  localparam logic [5:0] OFF_DEB0 = 6'h0c;
  localparam logic [5:0] OFF_DEB1 = 6'h0d;
  localparam logic [5:0] OFF_DEB2 = 6'h0e;
  localparam logic [5:0] OFF_FLAGS = 6'h14;
  localparam logic [5:0] OFF_GATE = 6'h15;
  localparam logic [5:0] OFF_RISE0 = 6'h18;
  localparam logic [5:0] OFF_RISE1 = 6'h19;
  localparam logic [5:0] OFF_RISE2 = 6'h1a;
  localparam logic [5:0] OFF_DROP0 = 6'h20;
  localparam logic [5:0] OFF_DROP1 = 6'h21;
  localparam logic [5:0] OFF_DROP2 = 6'h22;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STB_PERIOD = 0;
  localparam int STB_GLITCH = 1;
  localparam int STB_OVERRUN = 2;
  localparam int STB_EDGE = 3;
  localparam int FLG_EDGE = 0;
  localparam int FLG_OVERRUN = 1;
  localparam int FLG_IRQ = 2;
  localparam int GATE_EDGE = 0;
  localparam int GATE_OVERRUN = 1;
  localparam int GATE_GLOBAL = 2;
  localparam int GATE_RISE = 3;
  localparam int GATE_DROP = 4;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RELAY_RESET = 8'hff;
  localparam logic [4:0] GATE_RESET = 5'h18;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [19:0] PERIOD_RESET = 20'h00000;
  // Identity value is arbitrary
  localparam logic [7:0] IDENT_CODE = 8'h5a;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_MHZ = 40;
  localparam int STEP_NS = 200;
  localparam int STEP_CYCLES = (STEP_NS * CLOCK_MHZ) / 1000;
  localparam logic [3:0] STEP_LAST = 4'(STEP_CYCLES - 1);
endpackage

/* core/isolated_dio_filter_change_detect.sv */
// Register bank with glitch filters and change detection for isolated DIO
//
// Function
// - Input reads return current eight line levels
// - Relay registers power up all ones
// - Relay write sets controls, read returns it
// - Fixed identity byte at offset 06
// - Write-only clear register, ones trigger resets
// - Bit 3 clears edge flag; level history not reset
// - Overflow clears only with bits 2 and 3
// - Bit 1 resets glitch filter logic
// - Bit 0 reloads interval timer
// - Twenty-bit interval in 200 ns steps
// - Filter only lines with enable set
// - Three filter-enable registers, reset zero
// - Status bit 2 mirrors interrupt request
// - Status bit 1 flags edge during interrupt
// - Status bit 0 flags any enabled edge
// - Control bits 4 and 3 reset to one
// - Control bits 2..0 master, overflow, edge
// - Rising-edge enables at 18 to 1A
// - Falling-edge enables at 20 to 22
// - Edge interrupts need edge enable bit
`timescale 1ns/100ps
module isolated_dio_filter_change_detect (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [5:0] address,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  output logic [7:0] readData,
  input wire logic [23:0] inputLines,
  output logic [23:0] relayControl,
  output logic irqRequest
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [23:0] syncA_q;
  logic [23:0] syncB_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= inputLines;
      syncB_q <= syncA_q;
    end
  end

  // ****************************************************************
  // Register storage
  // ****************************************************************
  logic [7:0] relay_q [3];
  logic [7:0] debSel_q [3];
  logic [7:0] rise_q [3];
  logic [7:0] drop_q [3];
  logic [19:0] period_q;
  logic [4:0] gate_q;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b);
    hit = writeStrobe && (a == b);
  endfunction

  wire wrStrobeReg = hit(address, dio_regs_pkg::OFF_STROBE);
  wire [7:0] strobeBits = wrStrobeReg ? writeData : 8'h00;
  wire reloadTimer = strobeBits[dio_regs_pkg::STB_PERIOD];
  wire resetGlitch = strobeBits[dio_regs_pkg::STB_GLITCH];
  wire resetEdge = strobeBits[dio_regs_pkg::STB_EDGE];
  wire resetOverrun = resetEdge &&
    strobeBits[dio_regs_pkg::STB_OVERRUN];

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          relay_q[p] <= dio_regs_pkg::RELAY_RESET;
          debSel_q[p] <= dio_regs_pkg::SEL_RESET;
          rise_q[p] <= dio_regs_pkg::SEL_RESET;
          drop_q[p] <= dio_regs_pkg::SEL_RESET;
        end else begin
          if (hit(address, dio_regs_pkg::OFF_RLY3 + 6'(p))) begin
            relay_q[p] <= writeData;
          end
          if (hit(address, dio_regs_pkg::OFF_DEB0 + 6'(p))) begin
            debSel_q[p] <= writeData;
          end
          if (hit(address, dio_regs_pkg::OFF_RISE0 + 6'(p))) begin
            rise_q[p] <= writeData;
          end
          if (hit(address, dio_regs_pkg::OFF_DROP0 + 6'(p))) begin
            drop_q[p] <= writeData;
          end
        end
      end
      assign relayControl[8*p +: 8] = relay_q[p];
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      period_q <= dio_regs_pkg::PERIOD_RESET;
      gate_q <= dio_regs_pkg::GATE_RESET;
    end else begin
      if (hit(address, dio_regs_pkg::OFF_PER_LO)) begin
        period_q[7:0] <= writeData;
      end
      if (hit(address, dio_regs_pkg::OFF_PER_MID)) begin
        period_q[15:8] <= writeData;
      end
      if (hit(address, dio_regs_pkg::OFF_PER_HI)) begin
        period_q[19:16] <= writeData[3:0];
      end
      if (hit(address, dio_regs_pkg::OFF_GATE)) begin
        gate_q <= writeData[4:0];
      end
    end
  end

  // ****************************************************************
  // Filter interval timer
  // ****************************************************************
  // Step prescaler makes 200 ns ticks; the interval counter then
  // issues one sample pulse per programmed interval.
  logic [3:0] stepCnt_q;
  logic [19:0] periodCnt_q;
  wire stepTick = (stepCnt_q == dio_regs_pkg::STEP_LAST);
  wire periodDone = stepTick && (periodCnt_q <= 20'h00001);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stepCnt_q <= 4'h0;
      periodCnt_q <= dio_regs_pkg::PERIOD_RESET;
    end else if (reloadTimer) begin
      stepCnt_q <= 4'h0;
      periodCnt_q <= period_q;
    end else begin
      stepCnt_q <= stepTick ? 4'h0 : stepCnt_q + 4'h1;
      if (periodDone) begin
        periodCnt_q <= period_q;
      end else if (stepTick) begin
        periodCnt_q <= periodCnt_q - 20'h00001;
      end
    end
  end

  // ****************************************************************
  // Glitch filters
  // ****************************************************************
  // A line is accepted only if raw level stayed the same over a whole
  // interval: changed_q marks any disagreement since the last sample.
  logic [23:0] filt_q;
  logic [23:0] changed_q;
  logic [23:0] prevRaw_q;
  wire [23:0] selMask = {debSel_q[2], debSel_q[1], debSel_q[0]};
  wire [23:0] rawDiff = syncB_q ^ prevRaw_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      filt_q <= '0;
      changed_q <= '0;
      prevRaw_q <= '0;
    end else begin
      prevRaw_q <= syncB_q;
      if (resetGlitch) begin
        filt_q <= syncB_q;
        changed_q <= '0;
      end else if (periodDone) begin
        filt_q <= (filt_q & (changed_q | rawDiff)) |
          (syncB_q & ~(changed_q | rawDiff));
        changed_q <= '0;
      end else begin
        changed_q <= changed_q | rawDiff;
      end
    end
  end
  wire [23:0] cleanLevel = (selMask & filt_q) | (~selMask & syncB_q);

  // ****************************************************************
  // Change detection
  // ****************************************************************
  logic [23:0] lastLevel_q;
  logic edgeFlag_q;
  logic overrunFlag_q;
  wire [23:0] riseMask = {rise_q[2], rise_q[1], rise_q[0]};
  wire [23:0] dropMask = {drop_q[2], drop_q[1], drop_q[0]};
  wire [23:0] riseSeen = cleanLevel & ~lastLevel_q & riseMask &
    {24{gate_q[dio_regs_pkg::GATE_RISE]}};
  wire [23:0] dropSeen = ~cleanLevel & lastLevel_q & dropMask &
    {24{gate_q[dio_regs_pkg::GATE_DROP]}};
  wire anyEdge = |(riseSeen | dropSeen);
  wire irqNow = gate_q[dio_regs_pkg::GATE_GLOBAL] &&
    ((edgeFlag_q && gate_q[dio_regs_pkg::GATE_EDGE]) ||
     (overrunFlag_q && gate_q[dio_regs_pkg::GATE_OVERRUN]));
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lastLevel_q <= '0;
      edgeFlag_q <= 1'b0;
      overrunFlag_q <= 1'b0;
    end else begin
      // Level history resamples every cycle so no false edge follows a flag reset
      lastLevel_q <= cleanLevel;
      if (anyEdge) begin
        edgeFlag_q <= 1'b1;
      end else if (resetEdge) begin
        edgeFlag_q <= 1'b0;
      end
      if (anyEdge && irqNow) begin
        overrunFlag_q <= 1'b1;
      end else if (resetOverrun) begin
        overrunFlag_q <= 1'b0;
      end
    end
  end
  assign irqRequest = irqNow;

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire [7:0] flagsByte = {5'h00, irqNow, overrunFlag_q, edgeFlag_q};
  logic [7:0] readMux;
  always_comb begin
    unique case (address)
      dio_regs_pkg::OFF_IN0: readMux = syncB_q[7:0];
      dio_regs_pkg::OFF_IN1: readMux = syncB_q[15:8];
      dio_regs_pkg::OFF_IN2: readMux = syncB_q[23:16];
      dio_regs_pkg::OFF_RLY3: readMux = relay_q[0];
      dio_regs_pkg::OFF_RLY4: readMux = relay_q[1];
      dio_regs_pkg::OFF_RLY5: readMux = relay_q[2];
      dio_regs_pkg::OFF_IDENT: readMux = dio_regs_pkg::IDENT_CODE;
      dio_regs_pkg::OFF_PER_LO: readMux = period_q[7:0];
      dio_regs_pkg::OFF_PER_MID: readMux = period_q[15:8];
      dio_regs_pkg::OFF_PER_HI: readMux = {4'h0, period_q[19:16]};
      dio_regs_pkg::OFF_DEB0: readMux = debSel_q[0];
      dio_regs_pkg::OFF_DEB1: readMux = debSel_q[1];
      dio_regs_pkg::OFF_DEB2: readMux = debSel_q[2];
      dio_regs_pkg::OFF_FLAGS: readMux = flagsByte;
      dio_regs_pkg::OFF_GATE: readMux = {3'h0, gate_q};
      dio_regs_pkg::OFF_RISE0: readMux = rise_q[0];
      dio_regs_pkg::OFF_RISE1: readMux = rise_q[1];
      dio_regs_pkg::OFF_RISE2: readMux = rise_q[2];
      dio_regs_pkg::OFF_DROP0: readMux = drop_q[0];
      dio_regs_pkg::OFF_DROP1: readMux = drop_q[1];
      dio_regs_pkg::OFF_DROP2: readMux = drop_q[2];
      default: readMux = 8'h00;
    endcase
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readData <= 8'h00;
    end else if (readStrobe) begin
      readData <= readMux;
    end
  end
endmodule

/* bench/dio_regs_assertions.sv */
// Port-level checker for the isolated DIO register block
`timescale 1ns/100ps
module dio_regs_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [5:0] address,
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readData,
  input wire logic [23:0] inputLines,
  input wire logic [23:0] relayControl,
  input wire logic irqRequest
);
  // Shadow of the gate byte so request gating can be judged
  logic [4:0] gateCopy_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      gateCopy_q <= dio_regs_pkg::GATE_RESET;
    else if (writeStrobe && address == 6'h15)
      gateCopy_q <= writeData[4:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ident_read_a: assert property (
    readStrobe && address == 6'h06 |=> readData == dio_regs_pkg::IDENT_CODE)
    else $error("identity byte wrong");
  relay_write_a: assert property (
    writeStrobe && address == 6'h03 |=> relayControl[7:0] == $past(writeData))
    else $error("relay byte not taken");
  relay_reset_a: assert property (
    $rose(rst_b) |-> relayControl == 24'hffffff)
    else $error("relays not open after reset");
  input_read_a: assert property (
    $stable(inputLines)[*3] ##0 (readStrobe && address == 6'h00
    && $past(rst_b, 3)) |=> readData == $past(inputLines[7:0]))
    else $error("input byte wrong");
  strobe_read_a: assert property (
    readStrobe && address == 6'h07 |=> readData == 8'h00)
    else $error("clear byte readable");
  status_irq_a: assert property (
    readStrobe && address == 6'h14 |=> readData[2] == $past(irqRequest))
    else $error("status bit 2 not the request");
  irq_gate_a: assert property (
    irqRequest |-> gateCopy_q[2] && (gateCopy_q[0] || gateCopy_q[1]))
    else $error("request without enables");
  gate_read_a: assert property (
    readStrobe && address == 6'h15 |=> readData[4:0] == $past(gateCopy_q))
    else $error("gate byte readback wrong");
endmodule
bind isolated_dio_filter_change_detect dio_regs_checker chk (.clock(clock),
  .rst_b(rst_b), .address(address), .readStrobe(readStrobe),
  .writeStrobe(writeStrobe), .writeData(writeData), .readData(readData),
  .inputLines(inputLines), .relayControl(relayControl),
  .irqRequest(irqRequest));

/* bench/host_bus_model.sv */
// Host-side register access model driving the block's strobe bus
`timescale 1ns/100ps
module host_bus_model (
  input wire logic clock,
  output logic [5:0] address,
  output logic readStrobe,
  output logic writeStrobe,
  output logic [7:0] writeData,
  input wire logic [7:0] readData
);
  initial begin
    address = 6'h3f;
    readStrobe = 1'b0;
    writeStrobe = 1'b0;
    writeData = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
    // Stale data must not look valid once released
    writeData <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask
  task automatic setPeriod(input logic [19:0] p);
    wr(6'h08, p[7:0]);
    wr(6'h09, p[15:8]);
    wr(6'h0a, {4'h0, p[19:16]});
    wr(6'h07, 8'h01);
  endtask
endmodule

/* bench/tb.sv */
// Self-checking bench for the isolated DIO register block
`timescale 1ns/100ps
module tb;
  logic clock;
  logic rst_b;
  logic [23:0] inputLines;
  logic [5:0] address;
  logic readStrobe;
  logic writeStrobe;
  logic [7:0] writeData;
  logic [7:0] readData;
  logic [23:0] relayControl;
  logic irqRequest;
  int errTotal;
  int totalChecks;
  int cycles;
  host_bus_model host (.clock(clock), .address(address),
    .readStrobe(readStrobe), .writeStrobe(writeStrobe),
    .writeData(writeData), .readData(readData));
  isolated_dio_filter_change_detect uut (.clock(clock), .rst_b(rst_b),
    .address(address), .readStrobe(readStrobe), .writeStrobe(writeStrobe),
    .writeData(writeData), .readData(readData), .inputLines(inputLines),
    .relayControl(relayControl), .irqRequest(irqRequest));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input string n, input logic [23:0] e,
                     input logic [23:0] g);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Status bits 7..3 always read as zero; callers still mask them
  task automatic rc(input logic [5:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), {16'h0, e}, {16'h0, d & m});
  endtask
  task automatic drive(input logic [23:0] v, input int n);
    @(posedge clock);
    inputLines <= v;
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errTotal++;
      finishTest();
    end
  end
  initial begin
    rst_b = 1'b0;
    inputLines = 24'h0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    rc(6'h03, 8'hff);
    rc(6'h05, 8'hff);
    rc(6'h06, dio_regs_pkg::IDENT_CODE);
    rc(6'h15, 8'h18);
    rc(6'h0e, 8'h00);
    rc(6'h07, 8'h00);
    rc(6'h3f, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      host.wr(6'(3 + i), 8'(8'h3c + i));
      rc(6'(3 + i), 8'(8'h3c + i));
    end
    chk("relays", 24'h3e3d3c, relayControl);
    host.setPeriod(20'h5c312);
    rc(6'h08, 8'h12);
    rc(6'h0a, 8'h05);
    drive(24'ha5c30e, 3);
    rc(6'h00, 8'h0e);
    rc(6'h02, 8'ha5);
    $display("test ports done");
    host.wr(6'h18, 8'h01);
    host.wr(6'h20, 8'h01);
    rc(6'h20, 8'h01);
    host.wr(6'h15, 8'h1d);
    drive(24'ha5c30f, 4);
    chk("irq", 24'h1, {23'h0, irqRequest});
    rc(6'h14, 8'h05, 8'h07);
    drive(24'ha5c30e, 4);
    rc(6'h14, 8'h07, 8'h07);
    host.wr(6'h07, 8'h08);
    rc(6'h14, 8'h02, 8'h07);
    host.wr(6'h07, 8'h04);
    rc(6'h14, 8'h02, 8'h07);
    host.wr(6'h15, 8'h1e);
    rc(6'h14, 8'h06, 8'h07);
    chk("irq ovr", 24'h1, {23'h0, irqRequest});
    host.wr(6'h07, 8'h0c);
    rc(6'h14, 8'h00, 8'h07);
    host.wr(6'h15, 8'h1c);
    drive(24'ha5c30f, 4);
    chk("irq off", 24'h0, {23'h0, irqRequest});
    rc(6'h14, 8'h01, 8'h07);
    host.wr(6'h07, 8'h0c);
    host.wr(6'h15, 8'h09);
    drive(24'ha5c30e, 4);
    rc(6'h14, 8'h00, 8'h07);
    $display("test edges done");
    host.wr(6'h15, 8'h1d);
    drive(24'ha5c30c, 4);
    host.setPeriod(20'h00002);
    host.wr(6'h07, 8'h0e);
    host.wr(6'h0c, 8'h02);
    host.wr(6'h18, 8'h02);
    rc(6'h18, 8'h02);
    drive(24'ha5c30e, 3);
    drive(24'ha5c30c, 40);
    rc(6'h14, 8'h00, 8'h07);
    drive(24'ha5c30e, 60);
    rc(6'h14, 8'h05, 8'h07);
    host.wr(6'h22, 8'h80);
    host.wr(6'h07, 8'h0c);
    rc(6'h14, 8'h00, 8'h07);
    drive(24'h25c30e, 4);
    rc(6'h14, 8'h05, 8'h07);
    rc(6'h22, 8'h80);
    $display("test filter done");
    finishTest();
  end
endmodule
